// File: hs_counter_compare_set.sv
// high speed counters with compare-and-set slots
// assumes pulse inputs are synchronous to clk and the scan program
// raises scan_end once per scan
`timescale 1ns/10ps
`default_nettype none
module hs_counter_compare_set
  import hs_compare_pkg::*;
(
  input  wire  logic               clk,
  input  wire  logic               srst,
  input  wire  logic [CNT_N-1:0]   pulse_in,
  input  wire  logic [CNT_N-1:0]   count_down,
  input  wire  logic               count_wr,
  input  wire  logic [SEL_W-1:0]   count_wr_sel,
  input  wire  logic [CNT_W-1:0]   count_wr_data,
  input  wire  logic [CNT_N-1:0]   counter_preset_hit_clr,
  input  wire  logic               slot_load,
  input  wire  logic               slot_release,
  input  wire  logic [SLOT_W-1:0]  slot_index,
  input  wire  logic [CNT_W-1:0]   slot_preset,
  input  wire  logic [SEL_W-1:0]   slot_sel,
  input  wire  logic               slot_kind,
  input  wire  logic [BIT_W-1:0]   slot_bit,
  input  wire  logic [2:0]         slot_vec,
  input  wire  logic               bit_clr,
  input  wire  logic [BIT_W-1:0]   bit_clr_index,
  input  wire  logic               scan_end,
  input  wire  logic [CNT_N-1:0]   contact_preset_hit,
  input  wire  logic               counter_interrupt_inhibit_flag,
  input  wire  logic [VEC_N-1:0]   vector_ack,
  output logic [BIT_N-1:0]         target_bits,
  output logic [CNT_N-1:0]         scanned_contacts,
  output logic [VEC_N-1:0]         counter_interrupt_vectors,
  output logic [SLOT_N-1:0]        slot_active
);
  logic [CNT_W-1:0]  count [CNT_N];
  logic [CNT_N-1:0]  pulse_prev;
  logic [CNT_N-1:0]  pulse_hit;
  logic [SEL_W-1:0]  sel     [SLOT_N];
  logic [SLOT_N-1:0] fire;
  logic [SLOT_N-1:0] kind;
  logic [BIT_W-1:0]  tgt_bit [SLOT_N];
  logic [2:0]        tgt_vec [SLOT_N];
  logic [CNT_W-1:0]  next_count [CNT_N];
  logic [BIT_N-1:0]  bit_set;
  logic [VEC_N-1:0]  vec_set;

  // ==========================================================================
  // pulse edge detect and counters
  always_ff @(posedge clk)
  begin
    if (srst)
      pulse_prev <= '0;
    else
      pulse_prev <= pulse_in;
  end
  assign pulse_hit = pulse_in & ~pulse_prev;

  genvar c;
  generate
    for (c = 0; c < CNT_N; c++)
    begin : g_cnt
      assign next_count[c] = count_down[c] ? count[c] - 32'h0000_0001
                                           : count[c] + 32'h0000_0001;
      always_ff @(posedge clk)
      begin
        if (srst)
          count[c] <= COUNT_RST;
        else if (pulse_hit[c])
          count[c] <= next_count[c];
        else if (count_wr && (count_wr_sel == SEL_W'(c)))
          count[c] <= count_wr_data;
      end
    end
  endgenerate

  // ==========================================================================
  // comparison slots, compared against the post-increment or post-decrement value
  genvar s;
  generate
    for (s = 0; s < SLOT_N; s++)
    begin : g_slot
      hs_slot u_slot
      (
        .clk          (clk),
        .srst         (srst),
        .load         (slot_load && (slot_index == SLOT_W'(s))),
        .release_slot (slot_release && (slot_index == SLOT_W'(s))),
        .load_preset  (slot_preset),
        .load_sel     (slot_sel),
        .load_kind    (slot_kind),
        .load_bit     (slot_bit),
        .load_vec     (slot_vec),
        .pulse_hit    (pulse_hit),
        .sel_count    (next_count[sel[s]]),
        .sel          (sel[s]),
        .active       (slot_active[s]),
        .fire         (fire[s]),
        .kind         (kind[s]),
        .tgt_bit      (tgt_bit[s]),
        .tgt_vec      (tgt_vec[s])
      );
    end
  endgenerate
  // five slots only: the program keeps fewer than six comparisons live

  always_comb
  begin
    bit_set = '0;
    vec_set = '0;
    for (int i = 0; i < SLOT_N; i++)
    begin
      if (fire[i] && (kind[i] == TGT_BIT))
        bit_set[tgt_bit[i]] = 1'b1;
      if (fire[i] && (kind[i] == TGT_VEC) && (tgt_vec[i] < 3'(VEC_N)))
        vec_set[tgt_vec[i]] = 1'b1;
    end
  end

  // ==========================================================================
  // target bits: set wins over clear
  always_ff @(posedge clk)
  begin
    if (srst)
      target_bits <= OUT_RST;
    else
      target_bits <= (target_bits & ~(bit_clr ? (BIT_N'(1) << bit_clr_index) : '0))
                     | bit_set;
  end

  // interrupt requests, held until acknowledged, cleared while inhibited, set wins over ack
  always_ff @(posedge clk)
  begin
    if (srst || counter_interrupt_inhibit_flag)
      counter_interrupt_vectors <= VEC_RST;
    else
      counter_interrupt_vectors <= (counter_interrupt_vectors & ~vector_ack) | vec_set;
  end

  // ==========================================================================
  // contacts with no compare-and-set follow the scan
  always_ff @(posedge clk)
  begin
    if (srst)
      scanned_contacts <= '0;
    else if (scan_end)
      scanned_contacts <= (scanned_contacts & ~counter_preset_hit_clr)
                          | contact_preset_hit;
  end

  // ==========================================================================
  // checks
  sequence s_match(int i);
    fire[i] && (kind[i] == TGT_BIT);
  endsequence

  match_sets_bit_a: assert property (@(posedge clk) disable iff (srst)
    s_match(0) |=> target_bits[$past(tgt_bit[0])])
    else $error("matched slot did not set its bit");
  inhibit_vec_a: assert property (@(posedge clk) disable iff (srst)
    counter_interrupt_inhibit_flag |=> (counter_interrupt_vectors == '0))
    else $error("vector raised while inhibited");
  no_pulse_fire_a: assert property (@(posedge clk) disable iff (srst)
    (pulse_hit == '0) |-> (fire == '0))
    else $error("compare fired without counting pulse");
  vec_hold_a: assert property (@(posedge clk) disable iff (srst)
    (counter_interrupt_vectors[0] && !vector_ack[0] && !counter_interrupt_inhibit_flag)
    |=> counter_interrupt_vectors[0])
    else $error("vector dropped without ack");
  scan_hold_a: assert property (@(posedge clk) disable iff (srst)
    !scan_end |=> $stable(scanned_contacts))
    else $error("contact changed outside scan end");
  count_step_a: assert property (@(posedge clk) disable iff (srst)
    (pulse_hit[0] && !count_down[0]) |=> (count[0] == $past(count[0]) + 32'h0000_0001))
    else $error("counter did not step up");
  sel_range_a: assert property (@(posedge clk) disable iff (srst)
    slot_active[0] |-> ((sel[0] <= SEL_HI_A) || ((sel[0] >= SEL_LO_B) && (sel[0] <= SEL_HI_B))))
    else $error("slot armed on illegal counter");
  // the counter must land on the very preset that fired, all 32 bits
  fire_equal_a: assert property (@(posedge clk) disable iff (srst)
    fire[0] |=> (count[$past(sel[0])] == $past(g_slot[0].u_slot.preset)))
    else $error("fired on unequal count");
  bit_set_hit_a: assert property (@(posedge clk) disable iff (srst)
    (bit_set != '0) |=> ((target_bits & $past(bit_set)) == $past(bit_set)))
    else $error("matched bit not set at once");
  vec_raise_a: assert property (@(posedge clk) disable iff (srst)
    ((vec_set != '0) && !counter_interrupt_inhibit_flag)
    |=> ((counter_interrupt_vectors & $past(vec_set)) == $past(vec_set)))
    else $error("matched vector not raised");
  count_down_a: assert property (@(posedge clk) disable iff (srst)
    (pulse_hit[SEL_LO_B] && count_down[SEL_LO_B])
    |=> (count[SEL_LO_B] == $past(count[SEL_LO_B]) - 32'h0000_0001))
    else $error("counter did not step down");
  wr_hold_a: assert property (@(posedge clk) disable iff (srst)
    (count_wr && (count_wr_sel == SEL_LO_A) && !pulse_hit[0])
    |=> (count[0] == $past(count_wr_data)))
    else $error("software write lost");
  scan_set_a: assert property (@(posedge clk) disable iff (srst)
    scan_end
    |=> ((scanned_contacts & $past(contact_preset_hit)) == $past(contact_preset_hit)))
    else $error("contact not set at scan end");

  generate
    for (s = 1; s < SLOT_N; s++)
    begin : g_fire_chk
      fire_count_a: assert property (@(posedge clk) disable iff (srst)
        fire[s] |=> (count[$past(sel[s])] == $past(g_slot[s].u_slot.preset)))
        else $error("slot fired on a foreign preset");
    end
  endgenerate
endmodule // hs_counter_compare_set
`default_nettype wire

// File: hs_compare_pkg.sv
// package for the high speed counter compare-and-set block
// assumes a single 125 MHz clock domain and no register bus
`default_nettype none
package hs_compare_pkg;
  // ==========================================================================
  // sizes
  localparam int unsigned CNT_W       = 32;
  localparam int unsigned SLOT_N      = 5;
  localparam int unsigned SLOT_W      = 3;
  localparam int unsigned VEC_N       = 6;
  localparam int unsigned SEL_W       = 5;
  localparam int unsigned BIT_N       = 16;
  localparam int unsigned BIT_W       = 4;
  // ==========================================================================
  // counter selector ranges, offsets from the first high speed counter
  localparam logic [SEL_W-1:0] SEL_LO_A = 5'h00;
  localparam logic [SEL_W-1:0] SEL_HI_A = 5'h0E;
  localparam logic [SEL_W-1:0] SEL_LO_B = 5'h10;
  localparam logic [SEL_W-1:0] SEL_HI_B = 5'h13;
  localparam int unsigned      CNT_N    = 20;
  // ==========================================================================
  // reset values
  localparam logic [CNT_W-1:0] COUNT_RST  = 32'h0000_0000;
  localparam logic [BIT_N-1:0] OUT_RST    = 16'h0000;
  localparam logic [VEC_N-1:0] VEC_RST    = 6'h00;
  // ==========================================================================
  // target kinds
  typedef enum logic [0:0]
  {
    TGT_BIT = 1'b0,
    TGT_VEC = 1'b1
  } target_kind_t;
  // per-slot state
  typedef enum logic [1:0]
  {
    SLOT_IDLE  = 2'b00,
    SLOT_ARMED = 2'b01,
    SLOT_HIT   = 2'b11
  } slot_state_t;
endpackage
`default_nettype wire

// File: hs_slot.sv
// one compare-and-set comparison slot
// assumes counts and pulse strobe come from the counter bank of the top
`timescale 1ns/10ps
`default_nettype none
module hs_slot
  import hs_compare_pkg::*;
(
  input  wire  logic               clk,
  input  wire  logic               srst,
  input  wire  logic               load,
  input  wire  logic               release_slot,
  input  wire  logic [CNT_W-1:0]   load_preset,
  input  wire  logic [SEL_W-1:0]   load_sel,
  input  wire  logic               load_kind,
  input  wire  logic [BIT_W-1:0]   load_bit,
  input  wire  logic [2:0]         load_vec,
  input  wire  logic [CNT_N-1:0]   pulse_hit,
  input  wire  logic [CNT_W-1:0]   sel_count,
  output logic [SEL_W-1:0]         sel,
  output logic                     active,
  output logic                     fire,
  output logic                     kind,
  output logic [BIT_W-1:0]         tgt_bit,
  output logic [2:0]               tgt_vec
);
  logic [CNT_W-1:0] preset;
  slot_state_t      state;
  logic             sel_ok;

  // ==========================================================================
  // programmed setup
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      preset  <= COUNT_RST;
      sel     <= SEL_LO_A;
      kind    <= TGT_BIT;
      tgt_bit <= '0;
      tgt_vec <= '0;
    end
    else if (load)
    begin
      preset  <= load_preset;
      sel     <= load_sel;
      kind    <= load_kind;
      tgt_bit <= load_bit;
      tgt_vec <= load_vec;
    end
  end

  // only the two high speed counter ranges are legal targets;
  // range A starts at selector zero, so only its top bound is tested
  assign sel_ok = (load_sel <= SEL_HI_A) ||
                  ((load_sel >= SEL_LO_B) && (load_sel <= SEL_HI_B));

  always_ff @(posedge clk)
  begin
    if (srst || release_slot)
      state <= SLOT_IDLE;
    else if (load)
      state <= sel_ok ? SLOT_ARMED : SLOT_IDLE;
    else if (fire)
      state <= SLOT_HIT;
    else if (state == SLOT_HIT)
      state <= SLOT_ARMED;
  end

  assign active = (state != SLOT_IDLE);
  // compare only on a counting pulse; full 32-bit equality either direction
  assign fire = active && pulse_hit[sel] && (sel_count == preset);
endmodule // hs_slot
`default_nettype wire

// File: hs_pulse_src.sv
// far-side model: external pulse inputs of the high speed counters
// assumes the bench requests a pulse on one counter with go and idx
`timescale 1ns/10ps
`default_nettype none
module hs_pulse_src
  import hs_compare_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             go,
  input  wire logic [SEL_W-1:0] idx,
  output var  logic [CNT_N-1:0] pulse_in
);
  // ==========================================================================
  // one-cycle pulse, launched at the falling edge so the block sees clean edges
  logic             req = 1'b0;
  logic [SEL_W-1:0] req_idx = 5'h00;
  initial pulse_in = 20'h00000;
  always @(posedge clk)
  begin
    req     <= go;
    req_idx <= idx;
  end
  always @(negedge clk)
    pulse_in <= req ? (20'h00001 << req_idx) : 20'h00000;
endmodule // hs_pulse_src
`default_nettype wire

// File: tb.sv
// testbench for the compare-and-set block, expectation queue and watcher
// assumes hs_pulse_src drives the count inputs
`timescale 1ns/10ps
`default_nettype none
module tb
  import hs_compare_pkg::*;
;
  // ==========================================================================
  // signals
  logic clk = 1'b0, srst = 1'b1, count_wr, slot_load, slot_release, slot_kind, bit_clr;
  logic scan_end, inhibit, go;
  logic [CNT_N-1:0] pulse_in, count_down, hit_set, hit_clr, scanned;
  logic [SEL_W-1:0] wr_sel, slot_sel, go_idx;
  logic [CNT_W-1:0] wr_data, slot_preset, rnd;
  logic [SLOT_W-1:0] slot_index;
  logic [BIT_W-1:0] slot_bit, clr_idx;
  logic [2:0] slot_vec;
  logic [BIT_N-1:0] target_bits;
  logic [VEC_N-1:0] vecs, ack;
  logic [SLOT_N-1:0] slot_active;
  logic [21:0] exp_q[$];
  logic [21:0] seen = 22'h000000;
  int n_fail = 0, cmp_count = 0, cycles = 0, seed = 50;
  always #4 clk = ~clk;
  hs_pulse_src u_hs_pulse_src (.clk(clk), .go(go), .idx(go_idx), .pulse_in(pulse_in));
  hs_counter_compare_set u_hs_counter_compare_set (.clk(clk), .srst(srst),
    .pulse_in(pulse_in), .count_down(count_down), .count_wr(count_wr),
    .count_wr_sel(wr_sel), .count_wr_data(wr_data), .counter_preset_hit_clr(hit_clr),
    .slot_load(slot_load), .slot_release(slot_release), .slot_index(slot_index),
    .slot_preset(slot_preset), .slot_sel(slot_sel), .slot_kind(slot_kind),
    .slot_bit(slot_bit), .slot_vec(slot_vec), .bit_clr(bit_clr), .bit_clr_index(clr_idx),
    .scan_end(scan_end), .contact_preset_hit(hit_set),
    .counter_interrupt_inhibit_flag(inhibit), .vector_ack(ack),
    .target_bits(target_bits), .scanned_contacts(scanned),
    .counter_interrupt_vectors(vecs), .slot_active(slot_active));
  // ==========================================================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s exp %h got %h", what, exp, got);
      n_fail++;
    end
  end
  endtask
  task test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // any change of bits or vectors must match the oldest note
  always @(negedge clk)
    if (!srst && {vecs, target_bits} !== seen)
    begin
      seen = {vecs, target_bits};
      check("bits_vecs", seen, exp_q.size() ? exp_q.pop_front() : 22'h3FFFFF);
    end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      test_done;
    end
  end
  // ==========================================================================
  // drivers, all at the falling edge
  task clocks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task load(input logic [SLOT_W-1:0] s, input logic [SEL_W-1:0] sel,
            input logic [CNT_W-1:0] p, input logic k, input logic [BIT_W-1:0] b,
            input logic [2:0] v);
  begin
    {slot_index, slot_sel, slot_preset, slot_kind, slot_bit, slot_vec} = {s, sel, p, k, b, v};
    slot_load = 1'b1;
    clocks(1);
    slot_load = 1'b0;
    clocks(1);
  end
  endtask
  task wr(input logic [SEL_W-1:0] sel, input logic [CNT_W-1:0] d);
  begin
    {wr_sel, wr_data, count_wr} = {sel, d, 1'b1};
    clocks(1);
    count_wr = 1'b0;
    clocks(2);
  end
  endtask
  task pulse(input logic [SEL_W-1:0] i);
  begin
    {go, go_idx} = {1'b1, i};
    clocks(1);
    go = 1'b0;
    clocks(4);
  end
  endtask
  // ==========================================================================
  // scenarios
  initial
  begin
    {count_wr, slot_load, slot_release, slot_kind, bit_clr, scan_end, inhibit, go} = 8'h00;
    {count_down, hit_set, wr_sel, go_idx, wr_data, slot_sel, slot_preset} = '0;
    {slot_index, slot_bit, clr_idx, slot_vec, hit_clr, ack} = '0;
    clocks(8);
    srst = 1'b0;
    load(3'h0, 5'h0F, 32'h00000001, TGT_BIT, 4'h1, 3'h0);
    check("slot_active", 32'(slot_active), 32'h00000000);
    rnd = $random(seed);
    load(3'h0, 5'h00, rnd, TGT_BIT, 4'h1, 3'h0);
    check("slot_active", 32'(slot_active), 32'h00000001);
    wr(5'h00, rnd);
    wr(5'h00, (rnd ^ 32'h0001_0000) - 32'h1);
    pulse(5'h00);
    wr(5'h00, rnd - 32'h1);
    exp_q.push_back({6'h00, 16'h0002});
    pulse(5'h00);
    load(3'h1, 5'h10, 32'h00000064, TGT_BIT, 4'h2, 3'h0);
    count_down[16] = 1'b1;
    wr(5'h10, 32'h00000065);
    exp_q.push_back({6'h00, 16'h0006});
    pulse(5'h10);
    // slot 2 is reloaded per vector so no vector serves two slots
    for (int v = 0; v < 6; v++)
    begin
      slot_release = 1'b1;
      clocks(1);
      slot_release = 1'b0;
      load(3'h2, 5'h02, 32'(v + 10), TGT_VEC, 4'h0, 3'(v));
      wr(5'h02, 32'(v + 9));
      exp_q.push_back({6'h01 << v, 16'h0006});
      pulse(5'h02);
      exp_q.push_back({6'h00, 16'h0006});
      if (v[0])
        ack = 6'h01 << v;
      else
        inhibit = 1'b1;
      clocks(2);
      {ack, inhibit} = '0;
    end
    load(3'h3, 5'h03, 32'h00000001, TGT_VEC, 4'h0, 3'h6);
    pulse(5'h03);
    inhibit = 1'b1;
    wr(5'h02, 32'h0000000E);
    pulse(5'h02);
    inhibit = 1'b0;
    exp_q.push_back({6'h00, 16'h0004});
    {bit_clr, clr_idx} = {1'b1, 4'h1};
    clocks(1);
    bit_clr = 1'b0;
    hit_set[0] = 1'b1;
    clocks(3);
    check("scanned", 32'(scanned), 32'h00000000);
    scan_end = 1'b1;
    clocks(1);
    {scan_end, hit_set} = '0;
    clocks(2);
    check("scanned", 32'(scanned), 32'h00000001);
    {scan_end, hit_clr} = {1'b1, 20'h00001};
    clocks(1);
    {scan_end, hit_clr} = '0;
    clocks(2);
    check("scanned", 32'(scanned), 32'h00000000);
    check("queue_left", 32'(exp_q.size()), 32'h00000000);
    test_done;
  end
endmodule // tb
`default_nettype wire
